// [shared/dsrx_params.svh]
`ifndef DSRX_PARAMS_SVH
`define DSRX_PARAMS_SVH

// Channel geometry
`define DSRX_NUM_CH 24
`define DSRX_TS_W 5
`define DSRX_LAST_TS 5'h17
`define DSRX_SIG_W 4

// Host register map, byte addresses on an 8-bit port
`define DSRX_ADDR_W 8
`define DSRX_DATA_W 8
`define DSRX_BANK_MASK 8'he0
`define DSRX_OFS_CHAN_CTRL 8'h00
`define DSRX_OFS_SIG_CTRL 8'h20
`define DSRX_OFS_SIG_STORE 8'h40
`define DSRX_OFS_FRAMER_IRQ_ENABLE 8'h60
`define DSRX_OFS_BLOCK_IRQ_ENABLE 8'h61
`define DSRX_OFS_FRAMER_IRQ_STATUS 8'h62
`define DSRX_OFS_CFG 8'h63

// Field positions
`define DSRX_ZCS_HI 5
`define DSRX_ZCS_LO 4
`define DSRX_EXT_HI 1
`define DSRX_EXT_LO 0
`define DSRX_FRAMER_IRQ_ENABLE_SIG_BIT 5
`define DSRX_BLOCK_IRQ_ENABLE_FRM_BIT 1
`define DSRX_FRAMER_IRQ_STATUS_SIG_BIT 5
`define DSRX_CFG_RUR_BIT 0
`define DSRX_CFG_ESF_BIT 1
`define DSRX_SIG_A_BIT 3
`define DSRX_SIG_B_BIT 2
`define DSRX_SIG_C_BIT 1
`define DSRX_SIG_D_BIT 0

// Writable bits of the global registers
`define DSRX_FRAMER_IRQ_ENABLE_MASK 8'h20
`define DSRX_BLOCK_IRQ_ENABLE_MASK 8'h02
`define DSRX_CFG_MASK 8'h03

// Signaling frames within the multiframe, numbered from one
`define DSRX_FRM_A 5'h06
`define DSRX_FRM_B 5'h0c
`define DSRX_FRM_C 5'h12
`define DSRX_FRM_D 5'h18
`define DSRX_SF_LAST 5'h0c
`define DSRX_ESF_LAST 5'h18

// Suppression substitute patterns
`define DSRX_PAT_B7 8'h02
`define DSRX_PAT_B8 8'h01
`define DSRX_PAT_DDS 8'h98
`define DSRX_ZERO 8'h00

// Reset values
`define DSRX_RST_BYTE 8'h00
`define DSRX_RST_SIG 4'h0

`endif

// [shared/dsrx_pkg.sv]
`include "dsrx_params.svh"

package dsrx_pkg;

  // Zero code suppression scheme of one channel
  typedef enum logic [1:0] {
    DSRX_ZCS_NONE = 2'h0,
    DSRX_ZCS_B7 = 2'h1,
    DSRX_ZCS_ALT = 2'h2,
    DSRX_ZCS_DDS = 2'h3
  } dsrx_zcs_t;

  // Signaling extraction mode of one channel
  typedef enum logic [1:0] {
    DSRX_EXT_NONE = 2'h0,
    DSRX_EXT_16 = 2'h1,
    DSRX_EXT_4 = 2'h2,
    DSRX_EXT_2 = 2'h3
  } dsrx_ext_t;

  // One received channel octet with its place in the multiframe
  typedef struct packed {
    logic [7:0] octet;
    logic [`DSRX_TS_W-1:0] ts;
    logic [4:0] frame;
  } dsrx_pcm_t;

  // Host register port request
  typedef struct packed {
    logic [`DSRX_ADDR_W-1:0] addr;
    logic [`DSRX_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dsrx_host_req_t;

  // Masked update of one signaling store entry
  typedef struct packed {
    logic [`DSRX_SIG_W-1:0] mask;
    logic [`DSRX_SIG_W-1:0] data;
  } dsrx_sig_wr_t;

endpackage : dsrx_pkg

// [src/dsrx_sig_mem.sv]
`timescale 1ns/1ns
`include "dsrx_params.svh"

module dsrx_sig_mem #(
  parameter int W = `DSRX_SIG_W,
  parameter int D = `DSRX_NUM_CH,
  parameter int AW = `DSRX_TS_W
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Registered read ports
  input wire logic [AW-1:0] a_raddr,
  output logic [W-1:0] a_rdata,
  input wire logic [AW-1:0] b_raddr,
  output logic [W-1:0] b_rdata
);

  logic [W-1:0] mem_r [0:D-1];

  // Storage; cleared on reset so the first comparison has a known base
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= '0;
      end
    end else if (clk_en && we && (int'(waddr) < D)) begin
      mem_r[waddr] <= wdata;
    end
  end

  // Read registers; out-of-range addresses read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else if (clk_en) begin
      a_rdata <= (int'(a_raddr) < D) ? mem_r[a_raddr] : '0;
      b_rdata <= (int'(b_raddr) < D) ? mem_r[b_raddr] : '0;
    end
  end

endmodule : dsrx_sig_mem

// [src/dsrx_top.sv]
// Contract
// - Bit-7 scheme: stuffed second LSB decoded
// - Alternate scheme: LSB or bit 7 stuffed
// - Data scheme: substitute 0x98 recognised
// - Suppression select bits 5-4 choose scheme
// - Extract signaling in ESF, SF, loop carrier; only SF and ESF are handled here
// - Extraction bits 1-0 choose signaling code
// - Superframe offers transparent, two, four, sixteen code
// - SF two-code: frames 6,12 into A
// - SF four-code: frame 6 A, 12 B
// - SF sixteen-code fills only A and B
// - ESF two-code: frames 6,12,18,24 into A
// - ESF four-code: 6,18 A; 12,24 B
// - ESF sixteen-code: 6,12,18,24 into A-D
// - Changes compared, flagged at multiframe end
// - Interrupt needs both enables set
// - Store holds A bit3 down to D bit0
// - Status bit 5 set on enabled change
// - Status clears on read or host write
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "dsrx_params.svh"

module dsrx_top
  import dsrx_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Received framed PCM, one channel octet per valid cycle
  input wire logic pcm_valid,
  input wire dsrx_pcm_t pcm_in,
  // Payload toward terminal equipment
  output logic pay_valid_r,
  output dsrx_pcm_t pay_r,
  // Signaling update interrupt request
  output logic signaling_update_event_r,
  // Host register port
  input wire dsrx_host_req_t host_req,
  output logic [`DSRX_DATA_W-1:0] host_rdata
);

  // Host visible registers
  logic [`DSRX_DATA_W-1:0] rx_channel_control_r [0:`DSRX_NUM_CH-1];
  logic [`DSRX_DATA_W-1:0] rx_signaling_control_r [0:`DSRX_NUM_CH-1];
  logic [`DSRX_DATA_W-1:0] framer_irq_enable_r;
  logic [`DSRX_DATA_W-1:0] block_irq_enable_r;
  logic [`DSRX_DATA_W-1:0] irq_cfg_r;
  logic sig_status_r;
  logic [`DSRX_DATA_W-1:0] rdata_r;
  logic rd_store_r;

  // Extraction pipeline stage
  logic s1_valid_r;
  dsrx_pcm_t s1_r;
  dsrx_ext_t s1_mode_r;
  logic chg_pend_r;

  // Combinational helpers
  logic esf;
  logic rur;
  logic irq_en;
  logic ts_ok;
  dsrx_zcs_t cur_zcs;
  logic [`DSRX_SIG_W-1:0] st_old;
  logic [`DSRX_SIG_W-1:0] st_host_q;
  dsrx_sig_wr_t s1_wr;
  logic [`DSRX_SIG_W-1:0] s1_new;
  logic s1_we;
  logic s1_changed;
  logic mf_end;
  logic st_we;
  logic [`DSRX_TS_W-1:0] st_waddr;
  logic [`DSRX_SIG_W-1:0] st_wdata;
  logic host_st_wr;
  logic status_set;
  logic status_clr;

  // Channel bank hit: bank base matches and index is a real timeslot
  function automatic logic chan_hit(input logic [`DSRX_ADDR_W-1:0] addr,
                                    input logic [`DSRX_ADDR_W-1:0] base);
    chan_hit = ((addr & `DSRX_BANK_MASK) == base) &&
               (addr[`DSRX_TS_W-1:0] <= `DSRX_LAST_TS);
  endfunction : chan_hit

  // Frames whose channel LSB carries a robbed signaling bit
  function automatic logic sig_frame(input logic [4:0] frame, input logic is_esf);
    sig_frame = (frame == `DSRX_FRM_A) || (frame == `DSRX_FRM_B) ||
                (is_esf && ((frame == `DSRX_FRM_C) || (frame == `DSRX_FRM_D)));
  endfunction : sig_frame

  // Undo the far end's suppression; anything but the exact substitute passes
  function automatic logic [7:0] zcs_restore(input dsrx_zcs_t sel, input logic [7:0] octet,
                                             input logic sig_frm);
    zcs_restore = octet;
    unique case (sel)
      DSRX_ZCS_NONE: zcs_restore = octet;
      DSRX_ZCS_B7: begin
        if (octet == `DSRX_PAT_B7) zcs_restore = `DSRX_ZERO;
      end
      DSRX_ZCS_ALT: begin
        // Signaling frames stuff bit 7 so the zero signaling bit survives
        if (sig_frm && (octet == `DSRX_PAT_B7)) zcs_restore = `DSRX_ZERO;
        if (!sig_frm && (octet == `DSRX_PAT_B8)) zcs_restore = `DSRX_ZERO;
      end
      DSRX_ZCS_DDS: begin
        if (octet == `DSRX_PAT_DDS) zcs_restore = `DSRX_ZERO;
      end
    endcase
  endfunction : zcs_restore

  // Which store positions a frame writes under a given extraction mode
  function automatic logic [`DSRX_SIG_W-1:0] sig_mask(input dsrx_ext_t mode,
                                                      input logic [4:0] frame,
                                                      input logic is_esf);
    logic fa;
    logic fb;
    logic fc;
    logic fd;
    fa = (frame == `DSRX_FRM_A);
    fb = (frame == `DSRX_FRM_B);
    fc = is_esf && (frame == `DSRX_FRM_C);
    fd = is_esf && (frame == `DSRX_FRM_D);
    sig_mask = '0;
    unique case (mode)
      DSRX_EXT_NONE: sig_mask = '0;
      DSRX_EXT_16: begin
        // Superframe has no frames 18 and 24, so C and D stay untouched
        sig_mask[`DSRX_SIG_A_BIT] = fa;
        sig_mask[`DSRX_SIG_B_BIT] = fb;
        sig_mask[`DSRX_SIG_C_BIT] = fc;
        sig_mask[`DSRX_SIG_D_BIT] = fd;
      end
      DSRX_EXT_4: begin
        sig_mask[`DSRX_SIG_A_BIT] = fa || fc;
        sig_mask[`DSRX_SIG_B_BIT] = fb || fd;
      end
      DSRX_EXT_2: begin
        sig_mask[`DSRX_SIG_A_BIT] = fa || fb || fc || fd;
      end
    endcase
  endfunction : sig_mask

  // Global configuration decode
  assign esf = irq_cfg_r[`DSRX_CFG_ESF_BIT];
  assign rur = irq_cfg_r[`DSRX_CFG_RUR_BIT];
  assign irq_en = framer_irq_enable_r[`DSRX_FRAMER_IRQ_ENABLE_SIG_BIT] &&
                  block_irq_enable_r[`DSRX_BLOCK_IRQ_ENABLE_FRM_BIT];
  assign ts_ok = (pcm_in.ts <= `DSRX_LAST_TS);
  assign cur_zcs = ts_ok ?
      dsrx_zcs_t'(rx_channel_control_r[pcm_in.ts][`DSRX_ZCS_HI:`DSRX_ZCS_LO]) :
      DSRX_ZCS_NONE;

  // Payload path: one register, suppression undone on the way
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pay_valid_r <= 1'b0;
      pay_r <= '0;
    end else if (clk_en) begin
      pay_valid_r <= pcm_valid;
      if (pcm_valid) begin
        pay_r.octet <= zcs_restore(cur_zcs, pcm_in.octet, sig_frame(pcm_in.frame, esf));
        pay_r.ts <= pcm_in.ts;
        pay_r.frame <= pcm_in.frame;
      end
    end
  end

  // Extraction stage; old store value arrives from the memory in step with it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_valid_r <= 1'b0;
      s1_r <= '0;
      s1_mode_r <= DSRX_EXT_NONE;
    end else if (clk_en) begin
      s1_valid_r <= pcm_valid && ts_ok;
      s1_r <= pcm_in;
      s1_mode_r <= ts_ok ?
          dsrx_ext_t'(rx_signaling_control_r[pcm_in.ts][`DSRX_EXT_HI:`DSRX_EXT_LO]) :
          DSRX_EXT_NONE;
    end
  end

  // Masked merge keeps the positions the mode does not write
  assign s1_wr.mask = sig_mask(s1_mode_r, s1_r.frame, esf);
  assign s1_wr.data = {`DSRX_SIG_W{s1_r.octet[0]}};
  assign s1_new = (st_old & ~s1_wr.mask) | (s1_wr.data & s1_wr.mask);
  assign s1_we = s1_valid_r && (s1_wr.mask != '0);
  assign s1_changed = s1_we && (s1_new != st_old);
  assign mf_end = s1_valid_r && (s1_r.ts == `DSRX_LAST_TS) &&
                  (s1_r.frame == (esf ? `DSRX_ESF_LAST : `DSRX_SF_LAST));

  // Stream writes win the single write port; a colliding host write is dropped
  assign host_st_wr = host_req.wr && chan_hit(host_req.addr, `DSRX_OFS_SIG_STORE);
  assign st_we = s1_we || host_st_wr;
  assign st_waddr = s1_we ? s1_r.ts : host_req.addr[`DSRX_TS_W-1:0];
  assign st_wdata = s1_we ? s1_new : host_req.wdata[`DSRX_SIG_W-1:0];

  dsrx_sig_mem #(
    .W(`DSRX_SIG_W),
    .D(`DSRX_NUM_CH),
    .AW(`DSRX_TS_W)
  ) u_store (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .we(st_we),
    .waddr(st_waddr),
    .wdata(st_wdata),
    .a_raddr(pcm_in.ts),
    .a_rdata(st_old),
    .b_raddr(host_req.addr[`DSRX_TS_W-1:0]),
    .b_rdata(st_host_q)
  );

  // Change seen during the multiframe; a change in the closing cycle still counts
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chg_pend_r <= 1'b0;
    end else if (clk_en) begin
      if (mf_end) begin
        chg_pend_r <= 1'b0;
      end else if (s1_changed) begin
        chg_pend_r <= 1'b1;
      end
    end
  end

  // Status flag: set wins over either clear
  assign status_set = mf_end && (chg_pend_r || s1_changed) && irq_en;
  assign status_clr = (host_req.rd && rur && (host_req.addr == `DSRX_OFS_FRAMER_IRQ_STATUS)) ||
                      (host_req.wr && !rur && (host_req.addr == `DSRX_OFS_FRAMER_IRQ_STATUS) &&
                       host_req.wdata[`DSRX_FRAMER_IRQ_STATUS_SIG_BIT]);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sig_status_r <= 1'b0;
    end else if (clk_en) begin
      if (status_set) begin
        sig_status_r <= 1'b1;
      end else if (status_clr) begin
        sig_status_r <= 1'b0;
      end
    end
  end

  // Interrupt request follows the flag, gated by both enables
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      signaling_update_event_r <= 1'b0;
    end else if (clk_en) begin
      signaling_update_event_r <= sig_status_r && irq_en;
    end
  end

  // Per-channel control writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `DSRX_NUM_CH; i++) begin
        rx_channel_control_r[i] <= `DSRX_RST_BYTE;
        rx_signaling_control_r[i] <= `DSRX_RST_BYTE;
      end
    end else if (clk_en && host_req.wr) begin
      if (chan_hit(host_req.addr, `DSRX_OFS_CHAN_CTRL)) begin
        rx_channel_control_r[host_req.addr[`DSRX_TS_W-1:0]] <= host_req.wdata;
      end
      if (chan_hit(host_req.addr, `DSRX_OFS_SIG_CTRL)) begin
        rx_signaling_control_r[host_req.addr[`DSRX_TS_W-1:0]] <= host_req.wdata;
      end
    end
  end

  // Global register writes; reserved bits never store
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      framer_irq_enable_r <= `DSRX_RST_BYTE;
      block_irq_enable_r <= `DSRX_RST_BYTE;
      irq_cfg_r <= `DSRX_RST_BYTE;
    end else if (clk_en && host_req.wr) begin
      if (host_req.addr == `DSRX_OFS_FRAMER_IRQ_ENABLE) begin
        framer_irq_enable_r <= host_req.wdata & `DSRX_FRAMER_IRQ_ENABLE_MASK;
      end
      if (host_req.addr == `DSRX_OFS_BLOCK_IRQ_ENABLE) begin
        block_irq_enable_r <= host_req.wdata & `DSRX_BLOCK_IRQ_ENABLE_MASK;
      end
      if (host_req.addr == `DSRX_OFS_CFG) begin
        irq_cfg_r <= host_req.wdata & `DSRX_CFG_MASK;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= `DSRX_RST_BYTE;
      rd_store_r <= 1'b0;
    end else if (clk_en) begin
      rdata_r <= `DSRX_RST_BYTE;
      rd_store_r <= host_req.rd && chan_hit(host_req.addr, `DSRX_OFS_SIG_STORE);
      if (host_req.rd) begin
        if (chan_hit(host_req.addr, `DSRX_OFS_CHAN_CTRL)) begin
          rdata_r <= rx_channel_control_r[host_req.addr[`DSRX_TS_W-1:0]];
        end else if (chan_hit(host_req.addr, `DSRX_OFS_SIG_CTRL)) begin
          rdata_r <= rx_signaling_control_r[host_req.addr[`DSRX_TS_W-1:0]];
        end else if (host_req.addr == `DSRX_OFS_FRAMER_IRQ_ENABLE) begin
          rdata_r <= framer_irq_enable_r;
        end else if (host_req.addr == `DSRX_OFS_BLOCK_IRQ_ENABLE) begin
          rdata_r <= block_irq_enable_r;
        end else if (host_req.addr == `DSRX_OFS_FRAMER_IRQ_STATUS) begin
          rdata_r[`DSRX_FRAMER_IRQ_STATUS_SIG_BIT] <= sig_status_r;
        end else if (host_req.addr == `DSRX_OFS_CFG) begin
          rdata_r <= irq_cfg_r;
        end
      end
    end
  end

  // Store reads come from the memory's own read register
  assign host_rdata = rd_store_r ? {{(`DSRX_DATA_W-`DSRX_SIG_W){1'b0}}, st_host_q} : rdata_r;

  // Checks; they assume the enable stays high over each window
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  zcs_bit7_a: assert property (
    pcm_valid && cur_zcs == DSRX_ZCS_B7 && pcm_in.octet == `DSRX_PAT_B7
    |=> pay_valid_r && pay_r.octet == `DSRX_ZERO)
    else $error("bit-7 substitute not restored");

  zcs_alt_lsb_a: assert property (
    pcm_valid && cur_zcs == DSRX_ZCS_ALT && !sig_frame(pcm_in.frame, esf) &&
    pcm_in.octet == `DSRX_PAT_B8
    |=> pay_r.octet == `DSRX_ZERO)
    else $error("alternate substitute not restored");

  zcs_dds_a: assert property (
    pcm_valid && cur_zcs == DSRX_ZCS_DDS && pcm_in.octet == `DSRX_PAT_DDS
    |=> pay_r.octet == `DSRX_ZERO)
    else $error("data substitute not restored");

  zcs_off_a: assert property (
    pcm_valid && cur_zcs == DSRX_ZCS_NONE |=> pay_r.octet == $past(pcm_in.octet))
    else $error("payload altered with suppression off");

  ext_off_a: assert property (
    s1_valid_r && s1_mode_r == DSRX_EXT_NONE |-> !s1_we && !s1_changed)
    else $error("store updated with extraction off");

  sf_cd_kept_a: assert property (
    s1_we && !esf |-> s1_new[`DSRX_SIG_C_BIT:`DSRX_SIG_D_BIT] ==
                      st_old[`DSRX_SIG_C_BIT:`DSRX_SIG_D_BIT])
    else $error("superframe wrote C or D");

  sig_a_frame6_a: assert property (
    s1_valid_r && s1_mode_r != DSRX_EXT_NONE && s1_r.frame == `DSRX_FRM_A
    |-> s1_we && s1_new[`DSRX_SIG_A_BIT] == s1_r.octet[0])
    else $error("frame 6 LSB not stored as A");

  status_set_a: assert property (
    mf_end && (chg_pend_r || s1_changed) && irq_en
    |=> sig_status_r ##1 (sig_status_r || $past(status_clr)))
    else $error("status not set on enabled change");

  rur_clear_a: assert property (
    host_req.rd && rur && host_req.addr == `DSRX_OFS_FRAMER_IRQ_STATUS && !status_set |=> !sig_status_r)
    else $error("status survived reset-upon-read");

  irq_gate_a: assert property (
    signaling_update_event_r |-> $past(irq_en) && $past(sig_status_r))
    else $error("interrupt without both enables");

  cov_status_c: cover property (status_set ##[1:8] signaling_update_event_r);
  cov_dds_c: cover property (pcm_valid && cur_zcs == DSRX_ZCS_DDS &&
                             pcm_in.octet == `DSRX_PAT_DDS);
  cov_esf16_c: cover property (s1_we && esf && s1_mode_r == DSRX_EXT_16 &&
                               s1_r.frame == `DSRX_FRM_D);
  cov_rur_c: cover property (sig_status_r ##1 status_clr ##1 !sig_status_r);

endmodule : dsrx_top

// [tb/dsrx_pcm_src.sv]
`timescale 1ns/1ns
module dsrx_pcm_src
  import dsrx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control from the bench
  input wire logic go,
  input wire logic esf,
  input wire logic [3:0] sig_pat,
  // Framed stream toward the block
  output logic pcm_valid,
  output dsrx_pcm_t pcm_in,
  output logic busy
);
  logic [4:0] ts_r;
  logic [4:0] frm_r;
  logic [4:0] last;
  logic [7:0] oct;

  // Upper bits never all zero, so the line keeps its ones density
  always_comb begin
    oct = 8'h54;
    case (frm_r)
      5'h06: oct[0] = sig_pat[3];
      5'h0c: oct[0] = sig_pat[2];
      5'h12: oct[0] = sig_pat[1];
      5'h18: oct[0] = sig_pat[0];
      default: oct[0] = 1'b1;
    endcase
  end

  assign last = esf ? 5'h18 : 5'h0c;

  // One whole multiframe per go pulse, one octet per cycle; idle data toggles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      pcm_valid <= 1'b0;
      ts_r <= 5'h00;
      frm_r <= 5'h01;
      pcm_in <= '0;
    end else if (busy || go) begin
      busy <= 1'b1;
      pcm_valid <= 1'b1;
      pcm_in <= '{octet: oct, ts: ts_r, frame: frm_r};
      if (ts_r == 5'h17) begin
        ts_r <= 5'h00;
        frm_r <= (frm_r == last) ? 5'h01 : frm_r + 5'h01;
        busy <= (frm_r != last);
      end else begin
        ts_r <= ts_r + 5'h01;
      end
    end else begin
      pcm_valid <= 1'b0;
      pcm_in <= ~pcm_in;
    end
  end
endmodule : dsrx_pcm_src

// [tb/dsrx_top_tb.sv]
`timescale 1ns/1ns
module dsrx_top_tb
  import dsrx_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic tb_valid = 1'b0;
  dsrx_pcm_t tb_pcm = '0;
  logic go = 1'b0;
  logic esf = 1'b0;
  logic [3:0] sig_pat = 4'h0;
  dsrx_host_req_t hreq = '0;
  logic src_valid, busy, pay_valid_r, signaling_update_event_r;
  dsrx_pcm_t src_pcm, pay_r;
  logic [7:0] host_rdata;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  // Rows: scheme, frame, octet in, octet out
  localparam logic [22:0] ROWS [11] = '{
    {2'h0, 5'h01, 8'h02, 8'h02}, {2'h1, 5'h01, 8'h02, 8'h00}, {2'h1, 5'h01, 8'h03, 8'h03},
    {2'h1, 5'h01, 8'h01, 8'h01}, {2'h2, 5'h01, 8'h01, 8'h00}, {2'h2, 5'h06, 8'h02, 8'h00},
    {2'h2, 5'h01, 8'h02, 8'h02}, {2'h2, 5'h06, 8'h01, 8'h01}, {2'h3, 5'h01, 8'h98, 8'h00},
    {2'h3, 5'h01, 8'h99, 8'h99}, {2'h0, 5'h01, 8'h98, 8'h98}};

  dsrx_pcm_src src (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .esf(esf),
    .sig_pat(sig_pat), .pcm_valid(src_valid), .pcm_in(src_pcm), .busy(busy));

  // Bench octets win over the partner; the two never overlap in time
  dsrx_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .pcm_valid(src_valid | tb_valid), .pcm_in(tb_valid ? tb_pcm : src_pcm),
    .pay_valid_r(pay_valid_r), .pay_r(pay_r),
    .signaling_update_event_r(signaling_update_event_r), .host_req(hreq),
    .host_rdata(host_rdata));

  // Clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hreq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    hreq.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    hreq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    hreq.rd <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), host_rdata, e);
  endtask : rdc

  task automatic send(input logic [4:0] f, input logic [7:0] o);
    @(posedge core_clk);
    tb_valid <= 1'b1;
    tb_pcm <= '{octet: o, ts: 5'h05, frame: f};
    @(posedge core_clk);
    tb_valid <= 1'b0;
    @(negedge core_clk);
  endtask : send

  // One multiframe from the partner, then room for the status pipeline
  task automatic run(input logic e, input logic [3:0] p);
    @(posedge core_clk);
    esf <= e;
    sig_pat <= p;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 700 && busy !== 1'b0; i++) @(posedge core_clk);
    repeat (6) @(posedge core_clk);
    #1;
  endtask : run

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h62, 8'h00);
    rdc(8'h40, 8'h00);
    wr(8'h80, 8'h5a);
    rdc(8'h80, 8'h00);
    foreach (ROWS[i]) begin
      wr(8'h05, {2'h0, ROWS[i][22:21], 4'h0});
      rdc(8'h05, {2'h0, ROWS[i][22:21], 4'h0});
      send(ROWS[i][20:16], ROWS[i][15:8]);
      chk("pay_valid_r", pay_valid_r, 1'b1);
      chk("pay_r", pay_r, {ROWS[i][7:0], 5'h05, ROWS[i][20:16]});
    end
    // Every extraction code on its own timeslot; one enable alone
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h02);
    wr(8'h22, 8'h03);
    wr(8'h60, 8'h20);
    rdc(8'h21, 8'h02);
    run(1'b0, 4'b0100);
    rdc(8'h40, 8'h04);
    rdc(8'h41, 8'h04);
    rdc(8'h42, 8'h08);
    rdc(8'h43, 8'h00);
    wr(8'h43, 8'hfa);
    rdc(8'h43, 8'h0a);
    chk("event", signaling_update_event_r, 1'b0);
    rdc(8'h62, 8'h00);
    // Both enables, unchanged signaling; two-code rewrites A from frames 6 and 12,
    // so with unequal bits it changes every multiframe: park that channel
    wr(8'h61, 8'h02);
    wr(8'h22, 8'h00);
    run(1'b0, 4'b0100);
    rdc(8'h62, 8'h00);
    rdc(8'h42, 8'h08);
    // Extended superframe with a change, clear by write
    wr(8'h22, 8'h03);
    wr(8'h63, 8'h02);
    run(1'b1, 4'b1011);
    rdc(8'h40, 8'h0b);
    rdc(8'h41, 8'h0c);
    rdc(8'h42, 8'h08);
    chk("event", signaling_update_event_r, 1'b1);
    rdc(8'h62, 8'h20);
    rdc(8'h62, 8'h20);
    wr(8'h62, 8'h20);
    rdc(8'h62, 8'h00);
    chk("event", signaling_update_event_r, 1'b0);
    // Clear on read
    wr(8'h63, 8'h03);
    run(1'b1, 4'b0000);
    rdc(8'h40, 8'h00);
    rdc(8'h62, 8'h20);
    rdc(8'h62, 8'h00);
    // Reset after the last run returns registers to zero
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(8'h60, 8'h00);
    rdc(8'h63, 8'h00);
    rdc(8'h05, 8'h00);
    rdc(8'h43, 8'h00);
    // A write while the enable is low must not land
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h60, 8'h20);
    clk_en <= 1'b1;
    rdc(8'h60, 8'h00);
    report_and_stop();
  end
endmodule : dsrx_top_tb
